// ---- verilog/mesc_pkg.sv ----
package mesc_pkg;

    // ==================================================
    // Timing
    // ==================================================
    localparam longint MESC_CLK_HZ = 40000000;
    // Pass rate in millihertz, 2520.6 Hz
    localparam longint MESC_PASS_RATE_MHZ = 2520600;
    // Pass period rounds down to whole cycles
    localparam int MESC_PASS_CYCLES =
        int'((MESC_CLK_HZ * 1000) / MESC_PASS_RATE_MHZ);

    // ==================================================
    // Engine data word addresses
    // ==================================================
    localparam logic [9:0] MESC_ADDR_CONFIG = 10'h020;
    localparam logic [9:0] MESC_ADDR_SAG_THRESHOLD = 10'h024;
    localparam logic [9:0] MESC_ADDR_REAL_RATE = 10'h041;
    localparam logic [9:0] MESC_ADDR_REACT_RATE = 10'h042;
    localparam logic [9:0] MESC_ADDR_STATUS = 10'h080;

    // ==================================================
    // Reset values and field positions
    // ==================================================
    localparam logic [31:0] MESC_CONFIG_RST = 32'h00005020;
    localparam logic [31:0] MESC_SAG_THRESHOLD_RST = 32'h00000000;
    localparam logic [31:0] MESC_RATE_RST = 32'h00000000;
    localparam int MESC_CFG_WIDTH = 21;
    localparam int MESC_ST_F0_BIT = 28;
    localparam int MESC_ST_SAG_C_BIT = 27;
    localparam int MESC_ST_SAG_B_BIT = 26;
    localparam int MESC_ST_SAG_A_BIT = 25;
    localparam int MESC_SHUNT_SHIFT = 3;

    // Bits 20..0 of the configuration word
    typedef struct packed {
        logic [2:0] sag_enable;    // C, B, A
        logic sag_signal;
        logic host_temp_comp_select;
        logic [7:0] sag_sample_count;
        logic phase_select_high;
        logic phase_select_low;
        logic host_pulse_control_select;
        logic [2:0] shunt_gain;    // chan2, chan1, chan0
        logic pulse_fast;
        logic pulse_slow;
    } mesc_cfg_t;

    typedef struct packed {
        logic [9:0] addr;
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } mesc_host_req_t;

endpackage

// ---- verilog/mesc_sag_detect.sv ----
`timescale 1ns/1ps
module mesc_sag_detect
    import mesc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sample_stb,
    input wire logic [31:0] magnitude,
    input wire logic [31:0] threshold,
    input wire logic [7:0] count_limit,
    input wire logic enable,
    output logic sag_flag,
    output logic sag_event
);

    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic flag_reg;
    logic flag_next;
    logic event_reg;
    wire below = magnitude < threshold;
    wire above = magnitude > threshold;
    wire reached = ({1'b0, count_reg} + 9'h001) >= {1'b0, count_limit};

    // ==================================================
    // Count and flag
    // ==================================================
    always_comb begin
        count_next = count_reg;
        flag_next = flag_reg;
        if (!enable) begin
            count_next = 8'h00;
            flag_next = 1'b0;
        end else if (sample_stb) begin
            if (below) begin
                if (count_reg != 8'hff) begin
                    count_next = count_reg + 8'h01;
                end
                if (reached) begin
                    flag_next = 1'b1; // RULE6
                end
            end else begin
                count_next = 8'h00; // RULE16
                // Equal to threshold neither sets nor clears
                if (above) begin
                    flag_next = 1'b0; // RULE7
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 8'h00;
            flag_reg <= 1'b0;
            event_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            flag_reg <= flag_next;
            event_reg <= flag_next & ~flag_reg;
        end
    end

    assign sag_flag = flag_reg;
    assign sag_event = event_reg;

endmodule

// ---- verilog/mesc_engine_regs.sv ----
`timescale 1ns/1ps
// Contract
// RULE1: A pass-complete interrupt pulse goes to the host once per pass at 2520.6 Hz.
// RULE2: The status word sits at engine address 0x80 and may be read every pass.
// RULE3: Status flags show the result of the preceding pass, not the current one.
// RULE4: Status bits 31:29 and 24:0 always read zero.
// RULE5: Status bit 28 is a square wave at the mains fundamental frequency.
// RULE6: A phase sag flag (27 C, 26 B, 25 A) sets after the set count of low samples.
// RULE7: A set sag flag clears only once that phase rises above the threshold; the code also clears it when that phase's sag detection is disabled.
// RULE8: The configuration word sits at address 0x20 and resets to 0x5020.
// RULE9: Configuration bits 20, 19, 18 enable sag detection for phases C, B, A.
// RULE10: With configuration bit 17 set each sag event toggles the aux pulse pin; the code toggles once for events on several phases in one cycle.
// RULE11: Configuration bit 16 hands temperature compensation to the host.
// RULE12: Field 15:8 is the consecutive low-sample count, default 80, max 255.
// RULE13: A set shunt bit applies a further gain of 8 to that current channel.
// RULE14: With host pulse control set, pulse rates follow host-written values.
// RULE15: With host pulse control clear, pulse rates follow the energy sums.
// RULE16: A phase's low-sample count restarts on any sample not below threshold.
// RULE17: A phase with sag detection disabled gives no aux pulse signalling.
module mesc_engine_regs
    import mesc_pkg::*;
#(
    parameter int PASS_CYCLES = MESC_PASS_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [9:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [31:0] host_wdata,
    output logic [31:0] host_rdata,
    output logic host_rvalid,
    output logic pass_irq,
    input wire logic [31:0] phase_a_voltage,
    input wire logic [31:0] phase_b_voltage,
    input wire logic [31:0] phase_c_voltage,
    input wire logic [31:0] chan0_current,
    input wire logic [31:0] chan1_current,
    input wire logic [31:0] chan2_current,
    input wire logic [31:0] real_energy_sum,
    input wire logic [31:0] reactive_energy_sum,
    output logic [31:0] chan0_scaled,
    output logic [31:0] chan1_scaled,
    output logic [31:0] chan2_scaled,
    output logic [31:0] real_pulse_rate,
    output logic [31:0] reactive_pulse_rate,
    output logic host_temp_comp_active,
    output logic aux_pulse_output
);

    // ==================================================
    // Helpers
    // ==================================================
    function automatic logic [31:0] mag(input logic [31:0] v);
        mag = v[31] ? (~v + 32'h00000001) : v;
    endfunction

    function automatic logic [31:0] gain(input logic [31:0] v,
                                         input logic sel);
        gain = sel ? (v << MESC_SHUNT_SHIFT) : v;
    endfunction

    // ==================================================
    // Request decode
    // ==================================================
    mesc_host_req_t req;
    assign req = '{addr: host_addr, wr: host_wr, rd: host_rd,
                   wdata: host_wdata};

    wire hit_config = req.addr == MESC_ADDR_CONFIG;
    wire hit_thr = req.addr == MESC_ADDR_SAG_THRESHOLD;
    wire hit_real = req.addr == MESC_ADDR_REAL_RATE;
    wire hit_react = req.addr == MESC_ADDR_REACT_RATE;
    wire hit_status = req.addr == MESC_ADDR_STATUS;

    wire wr_config = req.wr & hit_config;
    wire wr_thr = req.wr & hit_thr;
    wire wr_real = req.wr & hit_real;
    wire wr_react = req.wr & hit_react;

    // ==================================================
    // Host-written registers
    // ==================================================
    mesc_cfg_t cfg_reg;
    logic [31:0] sag_threshold_reg;
    logic [31:0] host_real_pulse_rate_reg;
    logic [31:0] host_reactive_pulse_rate_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= mesc_cfg_t'(MESC_CONFIG_RST[MESC_CFG_WIDTH-1:0]); // RULE8
        end else if (wr_config) begin
            // Bits above 20 are not stored and read back as zero
            cfg_reg <= mesc_cfg_t'(req.wdata[MESC_CFG_WIDTH-1:0]); // RULE8
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sag_threshold_reg <= MESC_SAG_THRESHOLD_RST;
            host_real_pulse_rate_reg <= MESC_RATE_RST;
            host_reactive_pulse_rate_reg <= MESC_RATE_RST;
        end else begin
            if (wr_thr) begin
                sag_threshold_reg <= req.wdata;
            end
            if (wr_real) begin
                host_real_pulse_rate_reg <= req.wdata; // RULE14
            end
            if (wr_react) begin
                host_reactive_pulse_rate_reg <= req.wdata; // RULE14
            end
        end
    end

    // ==================================================
    // Pass timer
    // ==================================================
    logic [15:0] pass_cnt_reg;
    logic [15:0] pass_cnt_next;
    wire pass_end = pass_cnt_reg == 16'(PASS_CYCLES - 1);

    assign pass_cnt_next = pass_end ? 16'h0000 : pass_cnt_reg + 16'h0001;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pass_cnt_reg <= 16'h0000;
        end else begin
            pass_cnt_reg <= pass_cnt_next; // RULE1
        end
    end

    // ==================================================
    // Sag detection, one per phase
    // ==================================================
    logic [2:0] sag_flag;
    logic [2:0] sag_event;
    logic [31:0] phase_mag [3];

    assign phase_mag[0] = mag(phase_a_voltage);
    assign phase_mag[1] = mag(phase_b_voltage);
    assign phase_mag[2] = mag(phase_c_voltage);

    for (genvar i = 0; i < 3; i++) begin : g_sag
        mesc_sag_detect u_sag (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .sample_stb(pass_end),
            .magnitude(phase_mag[i]),
            .threshold(sag_threshold_reg),
            .count_limit(cfg_reg.sag_sample_count), // RULE12
            .enable(cfg_reg.sag_enable[i]), // RULE9
            .sag_flag(sag_flag[i]),
            .sag_event(sag_event[i])
        );
    end

    // ==================================================
    // Fundamental square wave
    // ==================================================
    // Follows the sign of phase A once per pass; the edges therefore land
    // on pass boundaries, so the period jitters by one pass at most.
    logic fundamental_square_wave_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fundamental_square_wave_reg <= 1'b0;
        end else if (pass_end) begin
            fundamental_square_wave_reg <= ~phase_a_voltage[31]; // RULE5
        end
    end

    // ==================================================
    // Status word
    // ==================================================
    // Latched at the pass edge from values the previous pass left behind,
    // so the host never sees a flag change while it reads.
    logic [31:0] status_reg;
    logic [31:0] status_next;

    always_comb begin
        status_next = 32'h00000000; // RULE4
        status_next[MESC_ST_F0_BIT] = fundamental_square_wave_reg; // RULE5
        status_next[MESC_ST_SAG_C_BIT] = sag_flag[2];
        status_next[MESC_ST_SAG_B_BIT] = sag_flag[1];
        status_next[MESC_ST_SAG_A_BIT] = sag_flag[0];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= 32'h00000000;
        end else if (pass_end) begin
            status_reg <= status_next; // RULE3
        end
    end

    // ==================================================
    // Pass-complete interrupt
    // ==================================================
    logic pass_irq_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pass_irq_reg <= 1'b0;
        end else begin
            pass_irq_reg <= pass_end; // RULE1
        end
    end

    // ==================================================
    // Read path
    // ==================================================
    logic [31:0] rdata_mux;
    logic [31:0] host_rdata_reg;
    logic host_rvalid_reg;

    assign rdata_mux =
        hit_config ? {{(32-MESC_CFG_WIDTH){1'b0}}, cfg_reg} :
        hit_thr ? sag_threshold_reg :
        hit_real ? host_real_pulse_rate_reg :
        hit_react ? host_reactive_pulse_rate_reg :
        hit_status ? status_reg : // RULE2
        32'h00000000;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata_reg <= 32'h00000000;
            host_rvalid_reg <= 1'b0;
        end else begin
            host_rvalid_reg <= req.rd;
            if (req.rd) begin
                host_rdata_reg <= rdata_mux;
            end
        end
    end

    // ==================================================
    // Aux pulse signalling
    // ==================================================
    // Disabled phases hold their flag low, so they raise no event here.
    logic aux_pulse_reg;
    wire sag_toggle = cfg_reg.sag_signal & (|sag_event); // RULE10 RULE17

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aux_pulse_reg <= 1'b0;
        end else if (sag_toggle) begin
            aux_pulse_reg <= ~aux_pulse_reg; // RULE10
        end
    end

    // ==================================================
    // Datapath outputs
    // ==================================================
    logic [31:0] chan0_scaled_reg;
    logic [31:0] chan1_scaled_reg;
    logic [31:0] chan2_scaled_reg;
    logic [31:0] real_rate_reg;
    logic [31:0] react_rate_reg;
    logic temp_comp_reg;

    wire [31:0] real_rate_sel = cfg_reg.host_pulse_control_select ?
        host_real_pulse_rate_reg : real_energy_sum; // RULE14 RULE15
    wire [31:0] react_rate_sel = cfg_reg.host_pulse_control_select ?
        host_reactive_pulse_rate_reg : reactive_energy_sum; // RULE14 RULE15

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chan0_scaled_reg <= 32'h00000000;
            chan1_scaled_reg <= 32'h00000000;
            chan2_scaled_reg <= 32'h00000000;
        end else begin
            chan0_scaled_reg <= gain(chan0_current, cfg_reg.shunt_gain[0]); // RULE13
            chan1_scaled_reg <= gain(chan1_current, cfg_reg.shunt_gain[1]); // RULE13
            chan2_scaled_reg <= gain(chan2_current, cfg_reg.shunt_gain[2]); // RULE13
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            real_rate_reg <= 32'h00000000;
            react_rate_reg <= 32'h00000000;
            temp_comp_reg <= 1'b0;
        end else begin
            real_rate_reg <= real_rate_sel;
            react_rate_reg <= react_rate_sel;
            temp_comp_reg <= cfg_reg.host_temp_comp_select; // RULE11
        end
    end

    assign host_rdata = host_rdata_reg;
    assign host_rvalid = host_rvalid_reg;
    assign pass_irq = pass_irq_reg;
    assign aux_pulse_output = aux_pulse_reg;
    assign chan0_scaled = chan0_scaled_reg;
    assign chan1_scaled = chan1_scaled_reg;
    assign chan2_scaled = chan2_scaled_reg;
    assign real_pulse_rate = real_rate_reg;
    assign reactive_pulse_rate = react_rate_reg;
    assign host_temp_comp_active = temp_comp_reg;

endmodule

// ---- sim/mesc_engine_regs_chk.sv ----
`timescale 1ns/1ps
module mesc_engine_regs_chk
    import mesc_pkg::*;
#(
    parameter int PASS_CYCLES = 20
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [9:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [31:0] host_wdata,
    input wire logic [31:0] host_rdata,
    input wire logic host_rvalid,
    input wire logic pass_irq,
    input wire logic [31:0] chan0_current,
    input wire logic [31:0] real_energy_sum,
    input wire logic [31:0] chan0_scaled,
    input wire logic [31:0] real_pulse_rate,
    input wire logic host_temp_comp_active,
    input wire logic aux_pulse_output
);
    // ==================================================
    // Shadow state
    // ==================================================
    // Registered outputs lag reset by a cycle, so checks wait for up_reg
    logic [31:0] cfg_reg;
    logic [15:0] gap_reg;
    logic seen_reg;
    logic [1:0] up_reg;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= MESC_CONFIG_RST;
            gap_reg <= 16'h0;
            seen_reg <= 1'b0;
            up_reg <= 2'h0;
        end else begin
            if (host_wr && host_addr == MESC_ADDR_CONFIG) begin
                cfg_reg <= host_wdata;
            end
            gap_reg <= pass_irq ? 16'h0 : gap_reg + 16'h1;
            seen_reg <= seen_reg | pass_irq;
            up_reg <= (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
        end
    end
    // ==================================================
    // Properties
    // ==================================================
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_rd_gives_rvalid: assert property (host_rd |=> host_rvalid)
        else $error("read strobe without valid");
    a_rvalid_has_cause: assert property (host_rvalid |-> $past(host_rd))
        else $error("valid without read");
    a_status_unused_zero: assert property (host_rvalid &&
        $past(host_addr) == MESC_ADDR_STATUS |->
        host_rdata[31:29] == 3'h0 && host_rdata[24:0] == 25'h0)
        else $error("status unused bits set");
    a_cfg_upper_zero: assert property (host_rvalid &&
        $past(host_addr) == MESC_ADDR_CONFIG |-> host_rdata[31:21] == 11'h0)
        else $error("config upper bits set");
    a_irq_period_exact: assert property (pass_irq && seen_reg |->
        gap_reg == PASS_CYCLES - 1)
        else $error("pass interval wrong");
    a_irq_not_late: assert property (seen_reg |-> gap_reg < PASS_CYCLES)
        else $error("pass interrupt late");
    a_temp_follows_cfg: assert property (up_reg == 2'h3 |->
        host_temp_comp_active == $past(cfg_reg[16]))
        else $error("temp select wrong");
    a_shunt_gain_eight: assert property (up_reg == 2'h3 |->
        chan0_scaled == ($past(cfg_reg[2]) ? $past(chan0_current) << 3
        : $past(chan0_current)))
        else $error("channel 0 gain wrong");
    a_rate_from_sums: assert property (up_reg == 2'h3 &&
        !$past(cfg_reg[5]) |-> real_pulse_rate == $past(real_energy_sum))
        else $error("real rate not from sum");
    a_aux_has_cause: assert property (up_reg == 2'h3 &&
        $changed(aux_pulse_output) |-> $past(pass_irq) && $past(cfg_reg[17]))
        else $error("aux pulse without event");
endmodule

bind mesc_engine_regs mesc_engine_regs_chk #(.PASS_CYCLES(PASS_CYCLES)) u_chk (
    .clk_sys, .rst_n, .host_addr, .host_wr, .host_rd, .host_wdata,
    .host_rdata, .host_rvalid, .pass_irq, .chan0_current, .real_energy_sum,
    .chan0_scaled, .real_pulse_rate, .host_temp_comp_active, .aux_pulse_output
);

// ---- sim/mesc_host_model.sv ----
`timescale 1ns/1ps
module mesc_host_model
    import mesc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [31:0] host_rdata,
    input wire logic host_rvalid,
    output mesc_host_req_t host_req
);
    // ==================================================
    // Host word access
    // ==================================================
    // Released lines show inverted values so stale data is never reused
    initial host_req = '0;
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        host_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clk_sys);
        host_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
    task automatic rd(input logic [9:0] a, output logic [31:0] d,
        output logic ok);
        int i;
        ok = 1'b0;
        d = 32'h0;
        @(negedge clk_sys);
        host_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~host_req.wdata};
        // Valid stands for one cycle only, so look on the release edge too
        for (i = 0; i < 4 && !ok; i++) begin
            @(negedge clk_sys);
            if (i == 0) begin
                host_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0,
                              wdata: ~host_req.wdata};
            end
            if (host_rvalid === 1'b1) begin
                d = host_rdata;
                ok = 1'b1;
            end
        end
    endtask
endmodule

// ---- sim/mesc_engine_regs_tb.sv ----
`timescale 1ns/1ps
module mesc_engine_regs_tb;
    import mesc_pkg::*;
    localparam int PASS = 20;
    localparam logic [31:0] NEG = 32'hffffff38;
    localparam logic [9:0] ST = MESC_ADDR_STATUS;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    mesc_host_req_t req;
    logic [31:0] rdata, s0, s1, s2, rp, qp;
    logic [31:0] va = 32'h1388, vb = 32'h1388, vc = 32'h1388;
    logic [31:0] i0 = 32'h5, i1 = 32'h6, i2 = 32'h7;
    logic [31:0] ws = 32'h333, vs = 32'h444;
    logic rvalid, irq, temp, aux, aux0;
    int error_cnt = 0;
    int n_compared = 0;
    always #12.5 clk_sys = ~clk_sys;
    mesc_host_model u_host (.clk_sys(clk_sys), .host_rdata(rdata),
        .host_rvalid(rvalid), .host_req(req));
    mesc_engine_regs #(.PASS_CYCLES(PASS)) u_dut (.clk_sys(clk_sys),
        .rst_n(rst_n), .host_addr(req.addr), .host_wr(req.wr),
        .host_rd(req.rd), .host_wdata(req.wdata), .host_rdata(rdata),
        .host_rvalid(rvalid), .pass_irq(irq), .phase_a_voltage(va),
        .phase_b_voltage(vb), .phase_c_voltage(vc), .chan0_current(i0),
        .chan1_current(i1), .chan2_current(i2), .real_energy_sum(ws),
        .reactive_energy_sum(vs), .chan0_scaled(s0), .chan1_scaled(s1),
        .chan2_scaled(s2), .real_pulse_rate(rp), .reactive_pulse_rate(qp),
        .host_temp_comp_active(temp), .aux_pulse_output(aux));
    // ==================================================
    // Tasks
    // ==================================================
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic hang();
        error_cnt++;
        $display("CHECK FAILED wait exp response got none");
        tally_and_finish();
    endtask
    task automatic rd_chk(input string what, input logic [9:0] a,
        input logic [31:0] exp);
        logic [31:0] d;
        logic ok;
        u_host.rd(a, d, ok);
        if (!ok) hang();
        chk(what, exp, d);
    endtask
    // Returns on the falling edge where the pass pulse is seen
    task automatic wait_irq(input int n);
        int k;
        int t;
        for (k = 0; k < n; k++) begin
            t = 0;
            do begin
                @(negedge clk_sys);
                t++;
            end while (irq !== 1'b1 && t < 3 * PASS);
            if (irq !== 1'b1) hang();
        end
    endtask
    // ==================================================
    // Sequence
    // ==================================================
    initial begin
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        rd_chk("config", MESC_ADDR_CONFIG, MESC_CONFIG_RST);
        rd_chk("unmapped", 10'h3ff, 32'h0);
        chk("temp", 32'h0, {31'h0, temp});
        chk("scaled0", i0, s0);
        chk("real rate", MESC_RATE_RST, rp);
        u_host.wr(MESC_ADDR_REAL_RATE, 32'h111);
        u_host.wr(MESC_ADDR_REACT_RATE, 32'h222);
        repeat (2) @(negedge clk_sys);
        chk("real rate", 32'h111, rp);
        chk("react rate", 32'h222, qp);
        $display("Test defaults done");
        u_host.wr(MESC_ADDR_SAG_THRESHOLD, 32'h3e8);
        u_host.wr(MESC_ADDR_CONFIG, 32'hffef0314);
        rd_chk("config", MESC_ADDR_CONFIG, 32'h000f0314);
        chk("temp", 32'h1, {31'h0, temp});
        chk("scaled0", i0 << 3, s0);
        chk("scaled1", i1, s1);
        chk("scaled2", i2 << 3, s2);
        chk("real rate", ws, rp);
        chk("react rate", vs, qp);
        wait_irq(2);
        u_host.wr(ST, 32'hffffffff);
        rd_chk("status", ST, 32'h10000000);
        $display("Test config done");
        aux0 = aux;
        wait_irq(1);
        va = NEG;
        vb = NEG;
        vc = NEG;
        wait_irq(3);
        rd_chk("status", ST, 32'h0);
        wait_irq(1);
        rd_chk("status", ST, 32'h06000000);
        chk("aux", {31'h0, ~aux0}, {31'h0, aux});
        va = 32'h3e8;
        vb = 32'h3e8;
        wait_irq(2);
        rd_chk("status", ST, 32'h16000000);
        vb = 32'h3e9;
        wait_irq(2);
        rd_chk("status", ST, 32'h12000000);
        $display("Test sag set and clear done");
        va = 32'h3e9;
        wait_irq(1);
        va = NEG;
        wait_irq(2);
        va = 32'h3e8;
        wait_irq(1);
        va = NEG;
        wait_irq(2);
        va = 32'h3e9;
        wait_irq(1);
        rd_chk("status", ST, 32'h0);
        chk("aux", {31'h0, ~aux0}, {31'h0, aux});
        $display("Test count restart done");
        tally_and_finish();
    end
endmodule
